// File: include/slp_pkg.sv
// package for the status LED pattern generator
// assumes a 100 MHz sys_clk; all pattern times are in milliseconds
package slp_pkg;
   // =====================================================
   // timing
   localparam int unsigned CLK_HZ          = 100_000_000;
   localparam int unsigned TICK_MS         = 1;
   localparam int unsigned TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
   localparam logic [16:0] TICK_LAST       = 17'(TICK_CYCLES - 1);
   localparam int unsigned BLINK_MS        = 200;
   localparam int unsigned FLICKER_MS      = 50;
   localparam int unsigned FLASH_ON_MS     = 200;
   localparam int unsigned FLASH_GAP_MS    = 200;
   localparam int unsigned FLASH_OFF_MS    = 1000;
   localparam int unsigned APL_OFF_MS      = 2000;
   localparam int unsigned APL_ON_MS       = 500;
   localparam int unsigned APL_GAP_MS      = 500;
   localparam int unsigned ACT_PULSE_MS    = 50;

   // =====================================================
   // patterns
   typedef enum logic [2:0] {
      slp_pat_off,
      slp_pat_on,
      slp_pat_blink,
      slp_pat_flicker,
      slp_pat_single,
      slp_pat_double,
      slp_pat_long1,
      slp_pat_long2
   } slp_pat_t;

   typedef enum logic [2:0] {
      slp_run_init,
      slp_run_preop,
      slp_run_boot,
      slp_run_safeop,
      slp_run_op
   } slp_run_state_t;

   // application indicator inputs
   typedef struct packed {
      logic initialised;
      logic init_error;
      logic first_port_cfg_error;
      logic second_port_cfg_error;
      logic first_port_cyclic;
      logic second_port_cyclic;
      logic gateway_running;
   } slp_apl_status_t;

   // master-mode inputs
   typedef struct packed {
      slp_run_state_t run_state;
      logic           comm_error;
      logic           link_up;
      logic           frame_activity;
   } slp_rte_status_t;

   typedef struct packed {
      logic apl_green;
      logic apl_red;
      logic run_green;
      logic err_red;
      logic link_green;
      logic act_yellow;
   } slp_leds_t;
endpackage

// File: tb/slp_led_panel.sv
// front panel model: watches the two application indicator lines
// assumes leds registered on sys_clk; a lit bicolour is one colour only
`timescale 1ns/1ps
`default_nettype none
module slp_led_panel (
   input  wire logic               sys_clk,
   input  wire logic               rst,
   input  wire slp_pkg::slp_leds_t leds,
   output var  logic               both_lit
);
   import slp_pkg::*;
   // =====================================================
   // sticky flag: both dies of the application indicator lit
   // would show as a mixed colour to the operator
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         both_lit <= 1'b0;
      end else if (leds.apl_green && leds.apl_red) begin
         both_lit <= 1'b1;
      end
   end
endmodule // slp_led_panel
`default_nettype wire

// File: tb/testbench.sv
// self-checking bench for the status LED pattern generator
// assumes slp_pkg compiled first; the ms tick never fires in this short run,
// so timed patterns are judged by their first phase only
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import slp_pkg::*;
   logic            sys_clk    = 1'b0;
   logic            rst        = 1'b1;
   slp_apl_status_t apl_status = '0;
   slp_rte_status_t rte_status = '0;
   slp_leds_t       leds;
   logic            both_lit;
   int              mismatches = 0;
   int              n_checks   = 0;
   int              cycles     = 0;

   always #5 sys_clk = ~sys_clk;

   slp_top uut (
      .sys_clk    (sys_clk),
      .rst        (rst),
      .apl_status (apl_status),
      .rte_status (rte_status),
      .leds       (leds)
   );

   slp_led_panel panel (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .leds     (leds),
      .both_lit (both_lit)
   );

   // =====================================================
   // helpers
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // inputs always move 1 ns after the rising edge
   task automatic step(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // whole run is under a hundred cycles; ceiling leaves ample margin
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         tally_and_finish();
      end
   end

   // =====================================================
   // scenarios
   task automatic test_reset();
      check({2'h0, leds}, 8'h00);
      rst = 1'b0;
      step(1);
      check({2'h0, leds}, 8'h00);
      $display("test reset done");
   endtask

   task automatic test_steady();
      rte_status.comm_error = 1'b1;
      step(1);
      check({7'h0, leds.err_red}, 8'h01);
      rte_status.link_up = 1'b1;
      step(1);
      check({6'h0, leds.link_green, leds.err_red}, 8'h03);
      rte_status.comm_error = 1'b0;
      rte_status.link_up    = 1'b0;
      step(1);
      check({6'h0, leds.link_green, leds.err_red}, 8'h00);
      $display("test steady done");
   endtask

   task automatic test_run();
      // every pattern but dark opens lit; 5..7 fold back to init
      logic [7:0] first_lit [8] = '{8'h0, 8'h1, 8'h1, 8'h1, 8'h1, 8'h0, 8'h0, 8'h0};
      for (int i = 0; i < 8; i++) begin
         rte_status.run_state = slp_run_state_t'(i[2:0]);
         step(2);
         check({7'h0, leds.run_green}, first_lit[i]);
      end
      rte_status.run_state = slp_run_preop;
      step(2);
      rte_status.run_state = slp_run_init;
      step(1);
      check({7'h0, leds.run_green}, 8'h01);
      step(1);
      check({7'h0, leds.run_green}, 8'h00);
      $display("test run done");
   endtask

   task automatic test_apl();
      // status bits, expected {green, red}; flash patterns open dark
      logic [6:0] st  [10] = '{7'h47, 7'h40, 7'h43, 7'h45, 7'h57, 7'h4f, 7'h67, 7'h20, 7'h07, 7'h47};
      logic [7:0] exp [10] = '{8'h2, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h1, 8'h1, 8'h0, 8'h2};
      for (int i = 0; i < 10; i++) begin
         apl_status = slp_apl_status_t'(st[i]);
         step(2);
         check({6'h0, leds.apl_green, leds.apl_red}, exp[i]);
      end
      apl_status = slp_apl_status_t'(7'h77);
      step(2);
      check({6'h0, leds.apl_green, leds.apl_red}, 8'h01);
      $display("test apl done");
   endtask

   task automatic test_act();
      check({7'h0, leds.act_yellow}, 8'h00);
      rte_status.frame_activity = 1'b1;
      step(1);
      rte_status.frame_activity = 1'b0;
      step(2);
      check({7'h0, leds.act_yellow}, 8'h01);
      step(20);
      check({7'h0, leds.act_yellow}, 8'h01);
      $display("test act done");
   endtask

   initial begin
      step(10);
      test_reset();
      test_steady();
      test_run();
      test_apl();
      test_act();
      check({7'h0, both_lit}, 8'h00);
      tally_and_finish();
   end
endmodule // testbench
`default_nettype wire

// File: verilog/slp_pattern.sv
// one indicator pattern sequencer, stepped by the ms tick
// assumes tick is a one-cycle pulse on sys_clk
`timescale 1ns/1ps
`default_nettype none
module slp_pattern (
   input  wire logic             sys_clk,
   input  wire logic             rst,
   input  wire logic             tick,
   input  wire slp_pkg::slp_pat_t pat,
   output var  logic             lit
);
   import slp_pkg::*;
   slp_pat_t    last_pat;
   logic [11:0] ms;
   logic [1:0]  phase;
   logic [11:0] phase_len;
   logic        phase_lit;
   logic [1:0]  last_phase;
   logic        restart;
   logic        phase_end;

   // =====================================================
   // phase table: length and level for each pattern/phase
   function automatic logic [12:0] phase_info(input slp_pat_t p, input logic [1:0] ph);
      case (p)
         slp_pat_blink:   phase_info = {ph[0] ? 1'b0 : 1'b1, 12'(BLINK_MS)};
         slp_pat_flicker: phase_info = {ph[0] ? 1'b0 : 1'b1, 12'(FLICKER_MS)};
         slp_pat_single:  phase_info = ph[0] ? {1'b0, 12'(FLASH_OFF_MS)}
                                             : {1'b1, 12'(FLASH_ON_MS)};
         slp_pat_double:  phase_info = (ph == 2'd3) ? {1'b0, 12'(FLASH_OFF_MS)}
                                     : (ph == 2'd1) ? {1'b0, 12'(FLASH_GAP_MS)}
                                     : {1'b1, 12'(FLASH_ON_MS)};
         slp_pat_long1:   phase_info = ph[0] ? {1'b1, 12'(APL_ON_MS)}
                                             : {1'b0, 12'(APL_OFF_MS)};
         slp_pat_long2:   phase_info = (ph == 2'd0) ? {1'b0, 12'(APL_OFF_MS)}
                                     : (ph == 2'd2) ? {1'b0, 12'(APL_GAP_MS)}
                                     : {1'b1, 12'(APL_ON_MS)};
         slp_pat_on:      phase_info = {1'b1, 12'h001};
         default:         phase_info = {1'b0, 12'h001};
      endcase
   endfunction

   assign {phase_lit, phase_len} = phase_info(pat, phase);
   assign last_phase = (pat == slp_pat_double || pat == slp_pat_long2) ? 2'd3 : 2'd1;
   assign restart    = (pat != last_pat);
   assign phase_end  = tick && (ms >= phase_len - 12'h1);

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         last_pat <= slp_pat_off;
         ms       <= '0;
         phase    <= '0;
         lit      <= 1'b0;
      end else begin
         last_pat <= pat;
         if (restart) begin
            ms    <= '0;
            phase <= '0;
         end else if (phase_end) begin
            ms    <= '0;
            phase <= (phase == last_phase) ? 2'd0 : phase + 2'd1;
         end else if (tick) begin
            ms    <= ms + 12'h1;
         end
         lit <= restart ? phase_info(pat, 2'd0) >> 12 == 13'h1 : phase_lit;
      end
   end
endmodule // slp_pattern
`default_nettype wire

// File: verilog/slp_tick.sv
// millisecond tick divider
// assumes sys_clk at the package clock rate
`timescale 1ns/1ps
`default_nettype none
module slp_tick (
   input  wire logic sys_clk,
   input  wire logic rst,
   output var  logic tick
);
   import slp_pkg::*;
   logic [16:0] count;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         count <= '0;
         tick  <= 1'b0;
      end else begin
         tick  <= (count == TICK_LAST);
         count <= (count == TICK_LAST) ? 17'h0 : count + 17'h1;
      end
   end
endmodule // slp_tick
`default_nettype wire

// File: verilog/slp_top.sv
// status LED pattern generator: application and master-mode indicators
// assumes status inputs come from other logic on sys_clk; leds drive pins
// Operation
// - both ports cyclic, gateway running: steady green
// - first port not cyclic: green long-off, one flash
// - second port not cyclic: green long-off, two flashes
// - first port config bad: red, one flash
// - second port config bad: red, two flashes
// - initialisation failure: steady red
// - run indicator dark in INIT
// - run indicator blinks in PRE-OPERATIONAL
// - run indicator flickers in boot state
// - run indicator single-flashes in SAFE-OPERATIONAL
// - run indicator steady in OPERATIONAL
// - error indicator red on communication error
// - link indicator lit while link established
// - activity indicator flashes on frame traffic
// - blink: 200 ms on, 200 ms off
// - flicker: 50 ms on, 50 ms off
// - single flash: 200 ms on, 1000 ms off
// - double flash: two 200 ms flashes, 1000 ms off
`timescale 1ns/1ps
`default_nettype none
module slp_top (
   input  wire logic                    sys_clk,
   input  wire logic                    rst,
   input  wire slp_pkg::slp_apl_status_t apl_status,
   input  wire slp_pkg::slp_rte_status_t rte_status,
   output var  slp_pkg::slp_leds_t      leds
);
   import slp_pkg::*;

   // =====================================================
   // application indicator selection
   logic     tick;
   slp_pat_t apl_pat;
   logic     apl_is_red;
   slp_pat_t run_pat;
   logic     apl_lit;
   logic     run_lit;
   logic [6:0] act_ms;
   logic       act_lit;

   assign apl_is_red = apl_status.init_error
                    || (apl_status.initialised
                        && (apl_status.first_port_cfg_error || apl_status.second_port_cfg_error));

   // priority chain: init error first, steady green last
   assign apl_pat = apl_status.init_error                  ? slp_pat_on    :
                    !apl_status.initialised                 ? slp_pat_off   :
                    apl_status.first_port_cfg_error         ? slp_pat_long1 :
                    apl_status.second_port_cfg_error        ? slp_pat_long2 :
                    !apl_status.first_port_cyclic           ? slp_pat_long1 :
                    !apl_status.second_port_cyclic          ? slp_pat_long2 :
                    apl_status.gateway_running              ? slp_pat_on    :
                    slp_pat_off;

   // =====================================================
   // run indicator selection
   assign run_pat = (rte_status.run_state == slp_run_preop)  ? slp_pat_blink   :
                    (rte_status.run_state == slp_run_boot)   ? slp_pat_flicker :
                    (rte_status.run_state == slp_run_safeop) ? slp_pat_single  :
                    (rte_status.run_state == slp_run_op)     ? slp_pat_on      :
                    slp_pat_off;

   slp_tick u_tick (
      .sys_clk (sys_clk),
      .rst     (rst),
      .tick    (tick)
   );

   slp_pattern u_apl (
      .sys_clk (sys_clk),
      .rst     (rst),
      .tick    (tick),
      .pat     (apl_pat),
      .lit     (apl_lit)
   );

   slp_pattern u_run (
      .sys_clk (sys_clk),
      .rst     (rst),
      .tick    (tick),
      .pat     (run_pat),
      .lit     (run_lit)
   );

   // =====================================================
   // activity: visible pulse started only from idle, then forced dark gap
   // so continuous traffic still looks like flashing
   // counter must hold twice the pulse length, so it is one bit wider than the pulse alone
   assign act_lit = (act_ms > 7'(ACT_PULSE_MS));

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         act_ms <= '0;
      end else if (act_ms == 7'h0) begin
         if (rte_status.frame_activity) begin
            act_ms <= 7'(2 * ACT_PULSE_MS);
         end
      end else if (tick) begin
         act_ms <= act_ms - 7'h1;
      end
   end

   // =====================================================
   // output flops; the pattern lit level is delayed one cycle here
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         leds <= '0;
      end else begin
         leds.apl_green  <= apl_lit && !apl_is_red;
         leds.apl_red    <= apl_lit && apl_is_red;
         leds.run_green  <= run_lit;
         leds.err_red    <= rte_status.comm_error;
         leds.link_green <= rte_status.link_up;
         leds.act_yellow <= act_lit;
      end
   end

   // =====================================================
   // checks
   property p_err_follows;
      @(posedge sys_clk) disable iff (rst)
         rte_status.comm_error |=> leds.err_red;
   endproperty
   a_err_follows: assert property (p_err_follows) else $error("error led not red");

   property p_link_follows;
      @(posedge sys_clk) disable iff (rst)
         !rte_status.link_up |=> !leds.link_green;
   endproperty
   a_link_follows: assert property (p_link_follows) else $error("link led lit without link");

   property p_init_dark;
      @(posedge sys_clk) disable iff (rst)
         (rte_status.run_state == slp_run_init)[*3] |-> !leds.run_green;
   endproperty
   a_init_dark: assert property (p_init_dark) else $error("run led lit in init");

   property p_op_steady;
      @(posedge sys_clk) disable iff (rst)
         (rte_status.run_state == slp_run_op)[*4] |-> leds.run_green;
   endproperty
   a_op_steady: assert property (p_op_steady) else $error("run led not steady in op");

   property p_init_err_red;
      @(posedge sys_clk) disable iff (rst)
         apl_status.init_error[*4] |-> leds.apl_red && !leds.apl_green;
   endproperty
   a_init_err_red: assert property (p_init_err_red) else $error("apl not steady red");

   property p_never_both;
      @(posedge sys_clk) disable iff (rst)
         !(leds.apl_red && leds.apl_green);
   endproperty
   a_never_both: assert property (p_never_both) else $error("apl both colours");

   property p_green_steady;
      @(posedge sys_clk) disable iff (rst)
         (apl_status.initialised && !apl_status.init_error && !apl_status.first_port_cfg_error
          && !apl_status.second_port_cfg_error && apl_status.first_port_cyclic
          && apl_status.second_port_cyclic && apl_status.gateway_running)[*4] |-> leds.apl_green;
   endproperty
   a_green_steady: assert property (p_green_steady) else $error("apl not steady green");

   property p_tick_period;
      @(posedge sys_clk) disable iff (rst)
         tick |=> !tick[*8];
   endproperty
   a_tick_period: assert property (p_tick_period) else $error("tick too frequent");

   property p_act_flash;
      @(posedge sys_clk) disable iff (rst)
         (act_ms == 7'h0 && rte_status.frame_activity) |=> ##1 leds.act_yellow;
   endproperty
   a_act_flash: assert property (p_act_flash) else $error("activity not flashed");

   c_red_cfg:  cover property (@(posedge sys_clk) disable iff (rst) apl_pat == slp_pat_long2 && apl_is_red);
   c_safeop:   cover property (@(posedge sys_clk) disable iff (rst) run_pat == slp_pat_single && leds.run_green);
   c_flicker:  cover property (@(posedge sys_clk) disable iff (rst) run_pat == slp_pat_flicker && leds.run_green);
   c_activity: cover property (@(posedge sys_clk) disable iff (rst) leds.act_yellow);
endmodule // slp_top
`default_nettype wire
